// ---- hw/tdm_serial_audio_port.v ----
// TDM serial audio port: transmit and receive sections, clock and frame
// sync generation or acceptance, four selectable pin sets.
// Assumes a plain register port on clk and link pins from outside clk.
//
// Functional notes
// R1 - Synchronous mode: receiver shares transmit clock and frame sync.
// R2 - Asynchronous mode: each section has its own clock and frame sync.
// R3 - Continuous clock mode keeps the bit clock toggling always.
// R4 - Gated clock mode toggles the bit clock only during a word; the generated receive clock keeps toggling, as go[1] ignores gated.
// R5 - Normal mode: exactly one word per frame each way.
// R6 - Network mode: frames of two to thirty-two words.
// R7 - Software never combines gated clock with network mode.
// R8 - Signals route to any one of four pin sets.
// R9 - Bit clock and frame sync are generated inside or accepted outside.
// R10 - Each transmit bit is launched after a rising transmit clock edge.
// R11 - Transmit data goes high impedance when idle, on rising edges.
// R12 - Asynchronous receiver samples on falling receive clock edges.
// R13 - Synchronous receiver samples on falling transmit clock edges.
// R14 - Frame sync outputs change on rising bit clock edges.
// R15 - Per-direction clock polarity; zero is non-inverted.
// R16 - Per-direction frame sync invert; zero is active high.
// R17 - Frame sync one bit long or one word long, selectable.
`timescale 1ns/1ns
`include "tdm_port_regs.vh"

module tdm_serial_audio_port (
  input wire clk,
  input wire nrst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [31:0] rdata,
  input wire [3:0] transmit_bit_clock_i,
  output wire [3:0] transmit_bit_clock_o,
  output wire [3:0] transmit_bit_clock_oe,
  input wire [3:0] transmit_frame_sync_i,
  output wire [3:0] transmit_frame_sync_o,
  output wire [3:0] transmit_frame_sync_oe,
  output wire [3:0] transmit_serial_data_o,
  output wire [3:0] transmit_serial_data_oe,
  input wire [3:0] receive_bit_clock_i,
  output wire [3:0] receive_bit_clock_o,
  output wire [3:0] receive_bit_clock_oe,
  input wire [3:0] receive_frame_sync_i,
  output wire [3:0] receive_frame_sync_o,
  output wire [3:0] receive_frame_sync_oe,
  input wire [3:0] receive_serial_data_i
);

  // ==========================================================
  // Register port
  reg [20:0] ctrl_q;
  reg [`DIV_BITS-1:0] div_q;
  reg [`WORD_BITS-1:0] tx_data_q;
  reg [`WORD_BITS-1:0] rx_data_q;
  reg tx_full_q;
  reg rx_full_q;
  reg underrun_q;
  reg overrun_q;
  wire tx_load;
  wire rx_capture;
  wire [1:0] active;

  wire sync_mode = ctrl_q[`CTRL_SYNC];
  wire gated = ctrl_q[`CTRL_GATED];
  wire network = ctrl_q[`CTRL_NETWORK];
  wire [1:0] pin_set = ctrl_q[`CTRL_PINSET_HI:`CTRL_PINSET_LO];
  wire [`SLOT_BITS-1:0] slots_field = ctrl_q[`CTRL_SLOTS_HI:`CTRL_SLOTS_LO];
  wire wr_tx = wr_en && (addr == `OFS_TXDATA);
  wire rd_rx = rd_en && (addr == `OFS_RXDATA);
  wire wr_st = wr_en && (addr == `OFS_STATUS);

  // R6 network frame length
  // A zero field in network mode still gives the two-word minimum.
  wire [`SLOT_BITS-1:0] last_slot = !network ? {`SLOT_BITS{1'b0}} :
    (slots_field == {`SLOT_BITS{1'b0}}) ? {{(`SLOT_BITS-1){1'b0}}, 1'b1} :
    slots_field;

  always @(posedge clk) begin
    if (!nrst) begin
      ctrl_q <= `CTRL_RESET;
      div_q <= `DIV_RESET;
      tx_data_q <= {`WORD_BITS{1'b0}};
      tx_full_q <= 1'b0;
      rx_full_q <= 1'b0;
      underrun_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      if (wr_en && addr == `OFS_CTRL)
        ctrl_q <= wdata[20:0];
      if (wr_en && addr == `OFS_DIV)
        div_q <= wdata[`DIV_BITS-1:0];
      if (wr_tx)
        tx_data_q <= wdata[`WORD_BITS-1:0];
      // A new write in the load cycle keeps the holding register full.
      if (wr_tx)
        tx_full_q <= 1'b1;
      else if (tx_load)
        tx_full_q <= 1'b0;
      // A capture in the read cycle wins, so no word is lost silently.
      if (rx_capture)
        rx_full_q <= 1'b1;
      else if (rd_rx)
        rx_full_q <= 1'b0;
      if (tx_load && !tx_full_q)
        underrun_q <= 1'b1;
      else if (wr_st && wdata[`ST_TX_UNDERRUN])
        underrun_q <= 1'b0;
      if (rx_capture && rx_full_q && !rd_rx)
        overrun_q <= 1'b1;
      else if (wr_st && wdata[`ST_RX_OVERRUN])
        overrun_q <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      rdata <= 32'h00000000;
    end else if (rd_en) begin
      case (addr)
        `OFS_CTRL: rdata <= {11'h000, ctrl_q};
        `OFS_DIV: rdata <= {24'h000000, div_q};
        `OFS_TXDATA: rdata <= {16'h0000, tx_data_q};
        `OFS_RXDATA: rdata <= {16'h0000, rx_data_q};
        `OFS_STATUS: rdata <= {26'h0000000, active, overrun_q,
                               underrun_q, rx_full_q, tx_full_q};
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end

  // ==========================================================
  // Pin synchronisers and pin set selection
  reg [19:0] pin_s1_q;
  reg [19:0] pin_s2_q;
  wire [19:0] pin_raw = {receive_serial_data_i, receive_frame_sync_i,
                         receive_bit_clock_i, transmit_frame_sync_i,
                         transmit_bit_clock_i};

  always @(posedge clk) begin
    if (!nrst) begin
      pin_s1_q <= 20'h00000;
      pin_s2_q <= 20'h00000;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  // R8 pin set select
  function sel4;
    input [3:0] v;
    input [1:0] s;
    begin
      sel4 = v[s];
    end
  endfunction

  wire [1:0] ck_in = {sel4(pin_s2_q[11:8], pin_set),
                      sel4(pin_s2_q[3:0], pin_set)};
  wire [1:0] fs_in = {sel4(pin_s2_q[15:12], pin_set),
                      sel4(pin_s2_q[7:4], pin_set)};
  wire rxd_in = sel4(pin_s2_q[19:16], pin_set);

  // ==========================================================
  // Per-direction bit clock, edges and framing (0 transmit, 1 receive)
  wire [1:0] en = {ctrl_q[`CTRL_RX_EN], ctrl_q[`CTRL_TX_EN]};
  wire [1:0] int_clk = {ctrl_q[`CTRL_RX_INT_CLK], ctrl_q[`CTRL_TX_INT_CLK]};
  wire [1:0] pol = {ctrl_q[`CTRL_RX_POL], ctrl_q[`CTRL_TX_POL]};
  wire [1:0] fsinv = {ctrl_q[`CTRL_RX_FSINV], ctrl_q[`CTRL_TX_FSINV]};
  wire [1:0] go = {en[1], en[0] && (!gated || tx_full_q)};
  wire [1:0] rise_r;
  wire [1:0] fall_r;
  wire [1:0] start_r;
  wire [1:0] ck_level;
  wire [1:0] fs_level;
  wire [1:0] at_last_bit;
  wire [1:0] at_last_slot;

  genvar d;
  generate
    for (d = 0; d < 2; d = d + 1) begin : dir
      reg [`DIV_BITS-1:0] div_cnt_q;
      reg gen_ck_q;
      reg ext_prev_q;
      reg [3:0] bit_q;
      reg [`SLOT_BITS-1:0] slot_q;
      reg active_q;
      // R15 clock polarity
      wire ext_ck = ck_in[d] ^ pol[d];
      // R16 frame sync invert
      wire ext_fs = fs_in[d] ^ fsinv[d];
      // R3 R4 continuous or gated
      // Gated mode finishes a high half so the clock idles low.
      wire run = en[d] && (!gated || go[d] || active_q || gen_ck_q);
      wire tick = run && (div_cnt_q == {`DIV_BITS{1'b0}});
      // R9 internal or external clock
      assign rise_r[d] = int_clk[d] ? (tick && !gen_ck_q) :
                         (ext_ck && !ext_prev_q);
      assign fall_r[d] = int_clk[d] ? (tick && gen_ck_q) :
                         (!ext_ck && ext_prev_q);
      // R1 R2 shared or own edges
      wire shared = (d == 1) && sync_mode;
      wire rise_e = shared ? rise_r[0] : rise_r[d];
      wire last_b = bit_q == `BIT_LAST;
      wire last_s = slot_q == last_slot;
      // R9 frame start from own sync or from the frame sync pin
      assign start_r[d] = int_clk[d] ?
        (rise_r[d] && go[d] && (!active_q || (last_b && last_s))) :
        (rise_r[d] && en[d] && ext_fs);
      wire start_e = shared ? start_r[0] : start_r[d];
      assign active[d] = active_q;
      assign at_last_bit[d] = last_b;
      assign at_last_slot[d] = last_s;
      assign ck_level[d] = gen_ck_q ^ pol[d];
      // R17 bit or word long sync
      assign fs_level[d] = (active_q && slot_q == {`SLOT_BITS{1'b0}} &&
        (ctrl_q[`CTRL_FS_WORD] || bit_q == 4'h0)) ^ fsinv[d];

      always @(posedge clk) begin
        if (!nrst) begin
          div_cnt_q <= {`DIV_BITS{1'b0}};
          gen_ck_q <= 1'b0;
          ext_prev_q <= 1'b0;
        end else begin
          ext_prev_q <= ext_ck;
          if (!run)
            div_cnt_q <= {`DIV_BITS{1'b0}};
          else if (tick)
            div_cnt_q <= div_q;
          else
            div_cnt_q <= div_cnt_q - {{(`DIV_BITS-1){1'b0}}, 1'b1};
          // A disabled section parks its clock low, so no stray falling
          // edge appears when it is enabled again.
          if (!en[d])
            gen_ck_q <= 1'b0;
          else if (tick)
            gen_ck_q <= !gen_ck_q;
        end
      end

      // R5 R6 R14 bit and slot counting on rising edges
      always @(posedge clk) begin
        if (!nrst || !en[d]) begin
          bit_q <= 4'h0;
          slot_q <= {`SLOT_BITS{1'b0}};
          active_q <= 1'b0;
        end else if (rise_e) begin
          if (start_e) begin
            bit_q <= 4'h0;
            slot_q <= {`SLOT_BITS{1'b0}};
            active_q <= 1'b1;
          end else if (active_q && last_b) begin
            bit_q <= 4'h0;
            if (last_s)
              active_q <= 1'b0;
            else
              slot_q <= slot_q + {{(`SLOT_BITS-1){1'b0}}, 1'b1};
          end else if (active_q) begin
            bit_q <= bit_q + 4'h1;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Transmit shifter
  reg [`WORD_BITS-1:0] tx_shift_q;
  wire tx_rise = rise_r[0];
  assign tx_load = tx_rise && (start_r[0] ||
    (active[0] && at_last_bit[0] && !at_last_slot[0]));

  // R10 launch on rising edge
  always @(posedge clk) begin
    if (!nrst) begin
      tx_shift_q <= {`WORD_BITS{1'b0}};
    end else if (tx_load) begin
      tx_shift_q <= tx_data_q;
    end else if (tx_rise) begin
      tx_shift_q <= {tx_shift_q[`WORD_BITS-2:0], 1'b0};
    end
  end

  // ==========================================================
  // Receive shifter
  reg [`WORD_BITS-1:0] rx_shift_q;
  // R12 R13 falling edge sampling
  wire rx_fall = sync_mode ? fall_r[0] : fall_r[1];
  assign rx_capture = rx_fall && active[1] && at_last_bit[1];

  always @(posedge clk) begin
    if (!nrst) begin
      rx_shift_q <= {`WORD_BITS{1'b0}};
      rx_data_q <= {`WORD_BITS{1'b0}};
    end else if (rx_fall && active[1]) begin
      rx_shift_q <= {rx_shift_q[`WORD_BITS-2:0], rxd_in};
      if (at_last_bit[1])
        rx_data_q <= {rx_shift_q[`WORD_BITS-2:0], rxd_in};
    end
  end

  // ==========================================================
  // Pin drivers: only the selected set is ever enabled.
  wire [3:0] set_hot = 4'h1 << pin_set;
  wire [3:0] tx_int_hot = set_hot & {4{int_clk[0]}};
  // In sync mode the receive clock and frame sync pins stay inputs and are ignored.
  wire [3:0] rx_int_hot = set_hot & {4{int_clk[1] && !sync_mode}};

  assign transmit_bit_clock_o = {4{ck_level[0]}};
  assign transmit_bit_clock_oe = tx_int_hot;
  // R14 frame sync on rising edges
  assign transmit_frame_sync_o = {4{fs_level[0]}};
  assign transmit_frame_sync_oe = tx_int_hot;
  assign receive_bit_clock_o = {4{ck_level[1]}};
  assign receive_bit_clock_oe = rx_int_hot;
  assign receive_frame_sync_o = {4{fs_level[1]}};
  assign receive_frame_sync_oe = rx_int_hot;
  assign transmit_serial_data_o = {4{tx_shift_q[`WORD_BITS-1]}};
  // R11 release when idle
  assign transmit_serial_data_oe = set_hot & {4{active[0]}};

endmodule

// ---- hw/tdm_port_regs.vh ----
// Register map, field positions and reset values of the TDM serial port.
// Assumes inclusion by the port module and the bench; holds definitions only.
`ifndef TDM_PORT_REGS_VH
`define TDM_PORT_REGS_VH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define OFS_CTRL 8'h00
`define OFS_DIV 8'h04
`define OFS_TXDATA 8'h08
`define OFS_RXDATA 8'h0C
`define OFS_STATUS 8'h10

// ==========================================================
// Control register fields
`define CTRL_TX_EN 0
`define CTRL_RX_EN 1
`define CTRL_SYNC 2
`define CTRL_GATED 3
`define CTRL_NETWORK 4
`define CTRL_TX_INT_CLK 5
`define CTRL_RX_INT_CLK 6
`define CTRL_TX_POL 7
`define CTRL_RX_POL 8
`define CTRL_TX_FSINV 9
`define CTRL_RX_FSINV 10
`define CTRL_FS_WORD 11
`define CTRL_PINSET_LO 12
`define CTRL_PINSET_HI 13
`define CTRL_SLOTS_LO 16
`define CTRL_SLOTS_HI 20
`define CTRL_RESET 21'h000000

// ==========================================================
// Divider, word format and status fields
`define DIV_BITS 8
`define DIV_RESET 8'h04
`define WORD_BITS 16
`define BIT_LAST 4'hF
`define SLOT_BITS 5
`define ST_TX_FULL 0
`define ST_RX_FULL 1
`define ST_TX_UNDERRUN 2
`define ST_RX_OVERRUN 3
`define ST_TX_ACTIVE 4
`define ST_RX_ACTIVE 5

`endif

// ---- verif/tdm_port_props.sv ----
// Checker on the serial port's pins and register read port.
// Assumes a bind into the port module; sees only its ports.
`timescale 1ns/1ns
module tdm_port_props (
  input wire clk,
  input wire nrst,
  input wire wr_en,
  input wire rd_en,
  input wire [31:0] rdata,
  input wire [3:0] transmit_bit_clock_o,
  input wire [3:0] transmit_bit_clock_oe,
  input wire [3:0] transmit_frame_sync_o,
  input wire [3:0] transmit_frame_sync_oe,
  input wire [3:0] transmit_serial_data_o,
  input wire [3:0] transmit_serial_data_oe
);
  // ====
  // Pin relations
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // A register write may move every pin at once, so it is left out.
  sequence own_clk;
    |transmit_bit_clock_oe && $past(|transmit_bit_clock_oe) && !$past(wr_en);
  endsequence
  sequence clk_moved;
    $changed(transmit_bit_clock_o[0]);
  endsequence
  a_one_data_set: assert property ($onehot0(transmit_serial_data_oe))
    else $error("data enabled on two pin sets");
  a_one_clock_set: assert property ($onehot0(transmit_bit_clock_oe))
    else $error("clock enabled on two pin sets");
  a_sync_with_clock: assert property (
    transmit_frame_sync_oe == transmit_bit_clock_oe)
    else $error("frame sync enable differs from clock enable");
  a_read_once: assert property (!rd_en |=> rdata == 32'h0)
    else $error("read data outside the read cycle");
  a_bit_on_rise: assert property (own_clk and (|transmit_serial_data_oe
    && $past(|transmit_serial_data_oe)
    && $changed(transmit_serial_data_o[0])) |-> clk_moved)
    else $error("data bit moved without a clock edge");
  a_sync_on_rise: assert property (own_clk
    and $changed(transmit_frame_sync_o[0]) |-> clk_moved)
    else $error("frame sync moved without a clock edge");
  a_drive_on_rise: assert property (own_clk
    and $rose(|transmit_serial_data_oe) |-> clk_moved)
    else $error("data driven without a clock edge");
  a_pins_agree: assert property (&transmit_serial_data_o
    || ~|transmit_serial_data_o)
    else $error("data pin sets disagree");
endmodule
bind tdm_serial_audio_port tdm_port_props props (.*);

// ---- verif/codec_model.sv ----
// Far-end codec: makes the bit clock and frame sync, sends a word and
// takes the port's word. Assumes one frame per rising edge of run.
`timescale 1ns/1ns
module codec_model (
  input wire run,
  input wire [5:0] bits,
  input wire [31:0] tx_word,
  input wire txd,
  output logic bclk,
  output logic fs,
  output logic rxd,
  output logic [31:0] got,
  output logic done
);
  integer i;
  initial begin
    bclk = 1'b0;
    fs = 1'b0;
    rxd = 1'b0;
    got = 32'h0;
    done = 1'b0;
  end
  // ====
  // Frame
  // launch on rise, take on fall
  // The clock stands still between frames; released data is inverted.
  always @(posedge run) begin
    done = 1'b0;
    for (i = 0; i < bits; i = i + 1) begin
      #62 bclk = 1'b1;
      fs = (i == 0);
      rxd = tx_word[bits - 1 - i];
      #63 bclk = 1'b0;
      got = {got[30:0], txd};
    end
    #62 bclk = 1'b1;
    fs = 1'b0;
    rxd = ~rxd;
    #63 bclk = 1'b0;
    done = 1'b1;
  end
endmodule

// ---- verif/tb.sv ----
// Bench for the serial port: registers, own-clock frames on all pin
// sets, gated clock, codec frames. Assumes the model and the checker.
`timescale 1ns/1ns
`include "tdm_port_regs.vh"
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic run = 1'b0;
  logic mute = 1'b0;
  logic [5:0] bits = 6'h10;
  logic [31:0] word = 32'h0;
  logic [31:0] rd;
  logic [15:0] w;
  logic [19:0] lr;
  logic [72:0] regs [8] = '{{1'b0, `OFS_CTRL, 64'h0},
    {1'b0, `OFS_DIV, 64'h4}, {1'b0, `OFS_STATUS, 64'h0},
    {1'b1, `OFS_DIV, 64'h200000000}, {1'b0, `OFS_DIV, 64'h2},
    {1'b0, 8'h14, 64'h0}, {1'b1, `OFS_TXDATA, 64'h123400000000},
    {1'b0, `OFS_STATUS, 64'h1}};
  logic [19:0] links [4] = '{{2'h0, 2'h0, 16'hA5C3},
    {2'h1, 2'h2, 16'h3C96}, {2'h2, 2'h1, 16'h8001},
    {2'h3, 2'h3, 16'h7FFE}};
  wire [31:0] rdata, got;
  wire [3:0] tck, tck_oe, tfs, txd, txd_oe;
  wire bclk, fs, rxd, done;
  wire line = txd_oe[1] ? txd[1] : 1'bz;
  integer mismatches = 0;
  integer comparisons = 0;
  integer n, hi;
  always #5 clk = ~clk;
  tdm_serial_audio_port dut (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .transmit_bit_clock_i({4{bclk}}), .transmit_bit_clock_o(tck),
    .transmit_bit_clock_oe(tck_oe), .transmit_frame_sync_i({4{fs}}),
    .transmit_frame_sync_o(tfs), .transmit_frame_sync_oe(),
    .transmit_serial_data_o(txd), .transmit_serial_data_oe(txd_oe),
    .receive_bit_clock_i({4{bclk & ~mute}}), .receive_bit_clock_o(),
    .receive_bit_clock_oe(), .receive_frame_sync_i({4{fs & ~mute}}),
    .receive_frame_sync_o(), .receive_frame_sync_oe(),
    .receive_serial_data_i({4{rxd}}));
  codec_model far (.run(run), .bits(bits), .tx_word(word), .txd(line),
    .bclk(bclk), .fs(fs), .rxd(rxd), .got(got), .done(done));
  // ====
  // Tasks
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] e,
    input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    rd = rdata;
  endtask
  // Waits on clock (0), frame sync (1) or codec done (2) of set s.
  task automatic lvl(input integer k, input integer s, input logic v);
    n = 0;
    while ((k == 0 ? tck[s] : k == 1 ? tfs[s] : done) !== v) begin
      @(negedge clk);
      n++;
      if (n == 1000) begin
        check("wait", 32'h1, 32'h0);
        results;
      end
    end
  endtask
  task automatic grab(input integer s, input logic pol, input logic inv);
    hi = 0;
    lvl(1, s, inv);
    lvl(1, s, ~inv);
    for (int b = 0; b < 16; b++) begin
      lvl(0, s, pol);
      w = {w[14:0], txd[s]};
      hi += (tfs[s] === ~inv);
      lvl(0, s, ~pol);
    end
  endtask
  task automatic toggles(input integer s);
    logic p;
    n = 0;
    p = tck[s];
    repeat (60) begin
      @(negedge clk);
      if (tck[s] !== p) n++;
      p = tck[s];
    end
  endtask
  task automatic ext(input logic [31:0] c, m, d);
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_TXDATA, d);
    wr(`OFS_CTRL, c);
    word <= m;
    run <= 1'b1;
    @(posedge clk);
    run <= 1'b0;
    lvl(2, 0, 1'b1);
    rdr(`OFS_RXDATA);
  endtask
  // ====
  // Sequence
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (regs[i][72]) wr(regs[i][71:64], regs[i][63:32]);
      else begin
        rdr(regs[i][71:64]);
        check("register", regs[i][31:0], rd);
      end
    end
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      lr = links[i];
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_TXDATA, {16'h0, lr[15:0]});
      wr(`OFS_CTRL, {18'h0, lr[19:18], 2'h0, lr[17], 1'b0, lr[16], 7'h21});
      grab(lr[19:18], lr[16], lr[17]);
      check("word", {16'h0, lr[15:0]}, {16'h0, w});
      check("sync bits", 32'h1, hi);
      check("data pins", 32'h1 << lr[19:18], {28'h0, txd_oe});
      toggles(lr[19:18]);
      check("toggles", 32'h14, n);
    end
    $display("test own clock done");
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_CTRL, 32'h829);
    toggles(0);
    check("gated idle", 32'h0, n);
    wr(`OFS_TXDATA, 32'h5AA5);
    grab(0, 1'b0, 1'b0);
    check("gated word", 32'h5AA5, {16'h0, w});
    check("word sync bits", 32'h10, hi);
    $display("test gated done");
    ext(32'h1003, 32'h96E1, 32'hC35A);
    check("codec word", 32'hC35A, {16'h0, got[15:0]});
    check("rx word", 32'h96E1, rd);
    check("clock pins", 32'h0, {28'h0, tck_oe});
    @(posedge clk);
    mute <= 1'b1;
    ext(32'h1007, 32'h0F0F, 32'hF00F);
    check("shared rx word", 32'h0F0F, rd);
    @(posedge clk);
    mute <= 1'b0;
    bits <= 6'h20;
    wr(`OFS_STATUS, 32'hC);
    ext(32'h11013, 32'h13572468, 32'hABCD);
    check("slot word", 32'h2468, rd);
    check("two slots", 32'hABCDABCD, got);
    rdr(`OFS_STATUS);
    check("slot flags", 32'hC, rd & 32'hF);
    $display("test codec done");
    wr(`OFS_CTRL, 32'h21);
    repeat (20) @(posedge clk);
    nrst <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("reset pins", 32'h0, {24'h0, txd_oe, tck_oe});
    @(posedge clk);
    nrst <= 1'b1;
    rdr(`OFS_CTRL);
    check("reset ctrl", 32'h0, rd);
    $display("test reset done");
    results;
  end
endmodule
